// ===== ssa_pkg.sv
// Constants, types and encodings for the sensor two-wire slave with alert response
// Operation
// R1: Answer alert response address with own address
// R2: Cause bit low above limit, high below
// R3: Polarity one inverts the cause bit
// R4: Arbitration winner clears alert after response
// R5: Arbitration loser keeps alert active
// R6: Pinless variant still answers alert response
// R7: Master polls pinless variant with alert command
// R8: Acknowledge general call with write bit
// R9: General call latch command resamples address pins
// R10: General call reset latches pins, resets registers
// R11: Master sends high-speed code after start
// R12: Never acknowledge high-speed code, enter high-speed
// R13: Master follows high-speed code with address
// R14: Leave high-speed mode on stop
// R15: Bus idle when both lines high
// R16: Falling data with clock high is start
// R17: Rising data with clock high is stop
// R18: Unlimited bytes, receiver acknowledges each byte (general call: code acknowledges only an 04 or 06 command byte, then no more)
// R19: Acknowledge holds data low through clock high
// R20: Master ends reads with not-acknowledge
// R21: Alert stays until register read or response
// R22: General call reset clears alert and mode
// R23: Address pins sampled after reset, then latched
// R24: Stop driving when released one reads zero
package ssa_pkg;

    localparam logic [6:0] ARA_ADDR = 7'h0c;
    localparam logic [6:0] GC_ADDR = 7'h00;
    localparam logic [7:0] GC_CMD_LATCH = 8'h04;
    localparam logic [7:0] GC_CMD_RESET = 8'h06;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [3:0] ADDR_BASE = 4'h9;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [6:0] ADDR_RESET = {ADDR_BASE, 3'h0};
    localparam logic RW_READ = 1'b1;
    localparam logic RW_WRITE = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK_SETUP = 4'h2,
        ST_ACK = 4'h3,
        ST_RX = 4'h4,
        ST_TX = 4'h5,
        ST_MACK_SETUP = 4'h6,
        ST_MACK = 4'h7,
        ST_WAIT = 4'h8
    } ssa_state_t;

    typedef enum logic [2:0] {
        MD_NONE = 3'h0,
        MD_WRITE = 3'h1,
        MD_READ = 3'h2,
        MD_ARA = 3'h3,
        MD_GC = 3'h4
    } ssa_mode_t;

endpackage : ssa_pkg

// ===== ssa_bus_if.sv
// Bus conditions passed from the line detector to the slave engine
interface ssa_bus_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic bus_idle;
    logic sda_level;

    modport det
    (
        output scl_rise,
        output scl_fall,
        output start_det,
        output stop_det,
        output bus_idle,
        output sda_level
    );

    modport ctl
    (
        input scl_rise,
        input scl_fall,
        input start_det,
        input stop_det,
        input bus_idle,
        input sda_level
    );
endinterface : ssa_bus_if

// ===== ssa_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain
module ssa_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("ssa_sync: WIDTH must be at least 1");
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            meta_reg <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : ssa_sync

// ===== ssa_cond.sv
// Edge, start, stop and idle detection on the synchronised bus lines
module ssa_cond (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_s,
    input wire logic sda_s,
    ssa_bus_if.det bus
);
    logic scl_prev_reg;
    logic sda_prev_reg;

    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_prev_reg <= scl_s;
            sda_prev_reg <= sda_s;
        end
    end

    assign bus.scl_rise = scl_s & ~scl_prev_reg;
    assign bus.scl_fall = ~scl_s & scl_prev_reg;
    assign bus.start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // R16
    assign bus.stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // R17
    assign bus.bus_idle = scl_s & sda_s; // R15
    assign bus.sda_level = sda_s;
endmodule : ssa_cond

// ===== ssa_top.sv
// Two-wire slave engine with alert response, general call and high-speed entry
module ssa_top #(
    parameter bit HAS_ALERT_PIN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_select_0,
    input wire logic addr_select_1,
    input wire logic alert_polarity,
    input wire logic interrupt_mode_wr,
    input wire logic interrupt_mode_wdata,
    input wire logic temp_alert_set,
    input wire logic temp_alert_below_low,
    input wire logic [7:0] tx_data,
    output logic tx_load,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic reg_read,
    output logic soft_reset,
    output logic interrupt_mode_select,
    output logic alert_active,
    output logic alert_pending,
    output logic hs_mode,
    output logic [6:0] slave_addr,
    output logic bus_free
);
    ssa_bus_if bus ();

    logic [3:0] pins_s;
    ssa_pkg::ssa_state_t state_reg;
    ssa_pkg::ssa_mode_t mode_reg;
    logic [2:0] cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] tx_sh_reg;
    logic ack_reg;
    logic sda_oe_reg;
    logic rx_valid_reg;
    logic [7:0] rx_data_reg;
    logic read_hit_reg;
    logic ara_won_reg;
    logic gc_latch_reg;
    logic gc_reset_reg;
    logic hs_enter_reg;
    logic tx_load_reg;
    logic pending_reg;
    logic cause_low_reg;
    logic tm_reg;
    logic capture_reg;
    logic [6:0] addr_reg;
    logic hs_reg;
    logic [7:0] byte_in;
    logic [7:0] tx_word;
    logic cause_bit;

    ssa_sync #(
        .WIDTH(4)
    ) u_sync (
        .clock(clock),
        .resetn(resetn),
        .async_in({addr_select_1, addr_select_0, sda_in, scl_in}),
        .sync_out(pins_s)
    );

    ssa_cond u_cond (
        .clock(clock),
        .resetn(resetn),
        .scl_s(pins_s[0]),
        .sda_s(pins_s[1]),
        .bus(bus)
    );

    assign byte_in = {shift_reg, bus.sda_level};
    assign cause_bit = cause_low_reg ^ alert_polarity; // R2 R3
    assign tx_word = (mode_reg == ssa_pkg::MD_ARA) ? {addr_reg, cause_bit} : tx_data; // R1

    // Bit engine
    always_ff @(posedge clock)
    begin
        rx_valid_reg <= 1'b0;
        read_hit_reg <= 1'b0;
        ara_won_reg <= 1'b0;
        gc_latch_reg <= 1'b0;
        gc_reset_reg <= 1'b0;
        hs_enter_reg <= 1'b0;
        tx_load_reg <= 1'b0;
        if (!resetn)
        begin
            state_reg <= ssa_pkg::ST_IDLE;
            mode_reg <= ssa_pkg::MD_NONE;
            cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            tx_sh_reg <= 8'h00;
            ack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            rx_data_reg <= 8'h00;
        end
        else if (bus.stop_det)
        begin
            state_reg <= ssa_pkg::ST_IDLE; // R17
            sda_oe_reg <= 1'b0;
            mode_reg <= ssa_pkg::MD_NONE;
        end
        else if (bus.start_det)
        begin
            state_reg <= ssa_pkg::ST_ADDR; // R16
            cnt_reg <= 3'h0;
            sda_oe_reg <= 1'b0;
            mode_reg <= ssa_pkg::MD_NONE;
        end
        else
        begin
            case (state_reg)
                ssa_pkg::ST_ADDR:
                begin
                    if (bus.scl_rise)
                    begin
                        shift_reg <= byte_in[6:0];
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == ssa_pkg::BIT_LAST)
                        begin
                            ack_reg <= 1'b1;
                            state_reg <= ssa_pkg::ST_ACK_SETUP;
                            if (byte_in[7:3] == ssa_pkg::HS_CODE_TOP)
                            begin
                                hs_enter_reg <= 1'b1; // R12
                                ack_reg <= 1'b0; // R12
                                state_reg <= ssa_pkg::ST_WAIT;
                            end
                            else if (byte_in[7:1] == addr_reg)
                            begin
                                if (byte_in[0] == ssa_pkg::RW_READ)
                                begin
                                    mode_reg <= ssa_pkg::MD_READ;
                                    read_hit_reg <= 1'b1; // R21
                                end
                                else
                                begin
                                    mode_reg <= ssa_pkg::MD_WRITE;
                                end
                            end
                            else if (byte_in == {ssa_pkg::ARA_ADDR, ssa_pkg::RW_READ}
                                     && tm_reg && pending_reg)
                            begin
                                mode_reg <= ssa_pkg::MD_ARA; // R1 R6
                            end
                            else if (byte_in == {ssa_pkg::GC_ADDR, ssa_pkg::RW_WRITE})
                            begin
                                mode_reg <= ssa_pkg::MD_GC; // R8
                            end
                            else
                            begin
                                ack_reg <= 1'b0;
                                state_reg <= ssa_pkg::ST_WAIT;
                            end
                        end
                    end
                end
                ssa_pkg::ST_RX:
                begin
                    if (bus.scl_rise)
                    begin
                        shift_reg <= byte_in[6:0];
                        cnt_reg <= cnt_reg + 3'h1;
                        if (cnt_reg == ssa_pkg::BIT_LAST)
                        begin
                            state_reg <= ssa_pkg::ST_ACK_SETUP;
                            if (mode_reg == ssa_pkg::MD_GC)
                            begin
                                mode_reg <= ssa_pkg::MD_NONE; // R8
                                ack_reg <= (byte_in == ssa_pkg::GC_CMD_LATCH)
                                           || (byte_in == ssa_pkg::GC_CMD_RESET);
                                gc_latch_reg <= (byte_in == ssa_pkg::GC_CMD_LATCH); // R9
                                gc_reset_reg <= (byte_in == ssa_pkg::GC_CMD_RESET); // R10
                            end
                            else
                            begin
                                ack_reg <= 1'b1; // R18
                                rx_data_reg <= byte_in;
                                rx_valid_reg <= 1'b1;
                            end
                        end
                    end
                end
                ssa_pkg::ST_ACK_SETUP:
                begin
                    if (bus.scl_fall)
                    begin
                        sda_oe_reg <= ack_reg; // R19
                        state_reg <= ssa_pkg::ST_ACK;
                    end
                end
                ssa_pkg::ST_ACK:
                begin
                    if (bus.scl_fall)
                    begin
                        cnt_reg <= 3'h0;
                        case (mode_reg)
                            ssa_pkg::MD_WRITE, ssa_pkg::MD_GC:
                            begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= ssa_pkg::ST_RX;
                            end
                            ssa_pkg::MD_READ, ssa_pkg::MD_ARA:
                            begin
                                sda_oe_reg <= ~tx_word[7];
                                tx_sh_reg <= {tx_word[6:0], 1'b0};
                                tx_load_reg <= (mode_reg == ssa_pkg::MD_READ);
                                state_reg <= ssa_pkg::ST_TX;
                            end
                            default:
                            begin
                                sda_oe_reg <= 1'b0;
                                state_reg <= ssa_pkg::ST_WAIT;
                            end
                        endcase
                    end
                end
                ssa_pkg::ST_TX:
                begin
                    if (bus.scl_rise)
                    begin
                        cnt_reg <= cnt_reg + 3'h1;
                        if (!sda_oe_reg && !bus.sda_level)
                        begin
                            state_reg <= ssa_pkg::ST_WAIT; // R24 R5
                        end
                        else if (cnt_reg == ssa_pkg::BIT_LAST)
                        begin
                            state_reg <= ssa_pkg::ST_MACK_SETUP;
                        end
                    end
                    else if (bus.scl_fall)
                    begin
                        sda_oe_reg <= ~tx_sh_reg[7];
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                    end
                end
                ssa_pkg::ST_MACK_SETUP:
                begin
                    if (bus.scl_fall)
                    begin
                        sda_oe_reg <= 1'b0;
                        state_reg <= ssa_pkg::ST_MACK;
                    end
                end
                ssa_pkg::ST_MACK:
                begin
                    if (bus.scl_rise)
                    begin
                        if (mode_reg == ssa_pkg::MD_ARA)
                        begin
                            ara_won_reg <= 1'b1; // R4
                            state_reg <= ssa_pkg::ST_WAIT;
                        end
                        else if (!bus.sda_level)
                        begin
                            state_reg <= ssa_pkg::ST_ACK; // R18
                        end
                        else
                        begin
                            state_reg <= ssa_pkg::ST_WAIT;
                        end
                    end
                end
                ssa_pkg::ST_IDLE, ssa_pkg::ST_WAIT:
                begin
                    sda_oe_reg <= 1'b0;
                end
                default:
                begin
                    state_reg <= ssa_pkg::ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Pending alert and its cause; a new event wins over any clear
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            pending_reg <= 1'b0;
            cause_low_reg <= 1'b0;
        end
        else if (temp_alert_set && tm_reg)
        begin
            pending_reg <= 1'b1;
            cause_low_reg <= temp_alert_below_low;
        end
        else if (gc_reset_reg || ara_won_reg || read_hit_reg)
        begin
            pending_reg <= 1'b0; // R4 R21 R22
        end
    end

    // Interrupt mode bit
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            tm_reg <= 1'b0;
        end
        else if (gc_reset_reg)
        begin
            tm_reg <= 1'b0; // R22
        end
        else if (interrupt_mode_wr)
        begin
            tm_reg <= interrupt_mode_wdata;
        end
    end

    // Address pin capture after reset or on general call
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            capture_reg <= 1'b1;
            addr_reg <= ssa_pkg::ADDR_RESET;
        end
        else if (gc_latch_reg || gc_reset_reg)
        begin
            capture_reg <= 1'b1; // R9 R10
        end
        else if (capture_reg)
        begin
            addr_reg <= {ssa_pkg::ADDR_BASE, pins_s[3], pins_s[2], 1'b0}; // R23
            capture_reg <= !bus.start_det;
        end
    end

    // High-speed mode flag
    always_ff @(posedge clock)
    begin
        if (!resetn)
        begin
            hs_reg <= 1'b0;
        end
        else if (bus.stop_det)
        begin
            hs_reg <= 1'b0; // R14
        end
        else if (hs_enter_reg)
        begin
            hs_reg <= 1'b1; // R12
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign tx_load = tx_load_reg;
    assign rx_data = rx_data_reg;
    assign rx_valid = rx_valid_reg;
    assign reg_read = read_hit_reg;
    assign soft_reset = gc_reset_reg;
    assign interrupt_mode_select = tm_reg;
    assign alert_active = HAS_ALERT_PIN & pending_reg; // R6
    assign alert_pending = pending_reg;
    assign hs_mode = hs_reg;
    assign slave_addr = addr_reg;
    assign bus_free = (state_reg == ssa_pkg::ST_IDLE) && bus.bus_idle; // R15
endmodule : ssa_top

// ===== ssa_checker.sv
// Concurrent checks on the sensor two-wire slave ports
module ssa_checker #(
    parameter bit HAS_ALERT_PIN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic interrupt_mode_wr,
    input wire logic interrupt_mode_wdata,
    input wire logic temp_alert_set,
    input wire logic reg_read,
    input wire logic soft_reset,
    input wire logic interrupt_mode_select,
    input wire logic alert_active,
    input wire logic alert_pending,
    input wire logic hs_mode,
    input wire logic bus_free
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    reset_clear_a: assert property ($rose(resetn) |-> !sda_oe && !hs_mode && !alert_pending)
        else $error("outputs not clear after reset");
    open_drain_a: assert property (sda_out == 1'b0)
        else $error("data output not held low");
    ack_setup_a: assert property ($rose(sda_oe) |-> !scl_in)
        else $error("data drive began with clock high");
    ack_stable_a: assert property ($rose(scl_in) && sda_oe |-> sda_oe [*4])
        else $error("data drive dropped during clock high");
    mode_write_a: assert property (interrupt_mode_wr && !soft_reset |=>
        soft_reset || interrupt_mode_select == $past(interrupt_mode_wdata))
        else $error("interrupt mode bit not written");
    alert_set_a: assert property (temp_alert_set && interrupt_mode_select && !soft_reset
        |=> alert_pending)
        else $error("alert not raised");
    alert_refuse_a: assert property (temp_alert_set && !interrupt_mode_select && !alert_pending
        |=> !alert_pending)
        else $error("alert raised outside interrupt mode");
    alert_pin_a: assert property ($rose(alert_pending) |-> ##[0:1] alert_active == HAS_ALERT_PIN)
        else $error("alert output wrong for variant");
    reset_cmd_a: assert property (soft_reset |-> ##[0:2] !interrupt_mode_select && !alert_pending)
        else $error("general call reset left mode or alert");
    hs_leave_a: assert property (hs_mode && scl_in && $rose(sda_in) |-> ##[1:6] !hs_mode)
        else $error("high-speed kept after stop");
    hs_hold_a: assert property ($fell(hs_mode) |-> scl_in && sda_in)
        else $error("high-speed left without stop");
    read_ack_a: assert property (reg_read |-> ##[1:12] sda_oe)
        else $error("own read address not acknowledged");
    idle_busy_a: assert property (!scl_in |-> ##[1:3] !bus_free)
        else $error("bus free while clock low");

    cover property ($rose(hs_mode));
    cover property (soft_reset);
    cover property (reg_read);
    cover property ($fell(alert_pending));
endmodule : ssa_checker

bind ssa_top ssa_checker #(.HAS_ALERT_PIN(HAS_ALERT_PIN)) u_chk (
    .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .interrupt_mode_wr(interrupt_mode_wr),
    .interrupt_mode_wdata(interrupt_mode_wdata), .temp_alert_set(temp_alert_set),
    .reg_read(reg_read), .soft_reset(soft_reset), .interrupt_mode_select(interrupt_mode_select),
    .alert_active(alert_active), .alert_pending(alert_pending), .hs_mode(hs_mode),
    .bus_free(bus_free));

// ===== ssa_master_model.sv
// Behavioural two-wire bus master, bit period 400 ns
module ssa_master_model (
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic put_bit(input logic b);
        sda_low = !b;
        #100 scl = 1'h1;
        #200 scl = 1'h0;
        #100;
    endtask : put_bit
    task automatic get_bit(output logic b);
        sda_low = 1'h0;
        #100 scl = 1'h1;
        #100 b = sda_line;
        #100 scl = 1'h0;
        #100;
    endtask : get_bit
    // Works from idle and as repeated start
    task automatic start();
        sda_low = 1'h0;
        #100 scl = 1'h1;
        #100 sda_low = 1'h1;
        #100 scl = 1'h0;
        #100;
    endtask : start
    task automatic stop();
        sda_low = 1'h1;
        #100 scl = 1'h1;
        #100 sda_low = 1'h0;
        #400;
    endtask : stop
    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) put_bit(d[i]);
        get_bit(b);
        ack = !b;
    endtask : write_byte
    task automatic read_byte(output logic [7:0] d, input logic last);
        logic b;
        for (int i = 7; i >= 0; i--)
        begin
            get_bit(b);
            d[i] = b;
        end
        put_bit(last);
    endtask : read_byte
endmodule : ssa_master_model

// ===== test_sensor_i2c_alert_response.sv
// Self-checking bench for the sensor two-wire slave port
module test_sensor_i2c_alert_response;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, resetn, addr_select_0, addr_select_1, alert_polarity, interrupt_mode_wr;
    logic interrupt_mode_wdata, temp_alert_set, temp_alert_below_low, tx_load, rx_valid;
    logic reg_read, soft_reset, interrupt_mode_select, alert_active, alert_pending, hs_mode;
    logic bus_free, sda_out, sda_oe, sda_out2, sda_oe2, alert_pending2, scl, sda_low, sda_line;
    logic [7:0] tx_data, rx_data, d;
    logic [6:0] slave_addr;
    logic ack, ack2, p, b;
    int num_errors, num_checks, cycles;

    assign sda_line = !(sda_low || (sda_oe && !sda_out) || (sda_oe2 && !sda_out2));
    ssa_master_model m (.scl(scl), .sda_low(sda_low), .sda_line(sda_line));
    ssa_top dut (.clock(clock), .resetn(resetn), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_0(addr_select_0),
        .addr_select_1(addr_select_1), .alert_polarity(alert_polarity),
        .interrupt_mode_wr(interrupt_mode_wr), .interrupt_mode_wdata(interrupt_mode_wdata),
        .temp_alert_set(temp_alert_set), .temp_alert_below_low(temp_alert_below_low),
        .tx_data(tx_data), .tx_load(tx_load), .rx_data(rx_data), .rx_valid(rx_valid),
        .reg_read(reg_read), .soft_reset(soft_reset), .interrupt_mode_select(interrupt_mode_select),
        .alert_active(alert_active), .alert_pending(alert_pending), .hs_mode(hs_mode),
        .slave_addr(slave_addr), .bus_free(bus_free));
    // Pinless variant at a fixed higher address, a rival in alert arbitration
    ssa_top #(.HAS_ALERT_PIN(1'b0)) dut2 (.clock(clock), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out2), .sda_oe(sda_oe2), .addr_select_0(1'h1),
        .addr_select_1(1'h1), .alert_polarity(alert_polarity),
        .interrupt_mode_wr(interrupt_mode_wr), .interrupt_mode_wdata(interrupt_mode_wdata),
        .temp_alert_set(temp_alert_set), .temp_alert_below_low(temp_alert_below_low),
        .tx_data(tx_data), .tx_load(), .rx_data(), .rx_valid(), .reg_read(), .soft_reset(),
        .interrupt_mode_select(), .alert_active(), .alert_pending(alert_pending2), .hs_mode(),
        .slave_addr(), .bus_free());

    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic pulse(input logic mode_wr, input logic mode_val, input logic alert);
        @(posedge clock);
        interrupt_mode_wr <= mode_wr;
        interrupt_mode_wdata <= mode_val;
        temp_alert_set <= alert;
        @(posedge clock);
        interrupt_mode_wr <= 1'h0;
        temp_alert_set <= 1'h0;
        @(posedge clock);
        @(negedge clock);
    endtask : pulse

    task automatic xfer(input logic [7:0] a, input logic [7:0] v);
        @(negedge clock);
        m.start();
        m.write_byte(a, ack);
        m.write_byte(v, ack2);
        m.stop();
    endtask : xfer

    // Alert response address with read bit; byte read only when acknowledged
    task automatic ara();
        @(negedge clock);
        m.start();
        m.write_byte(8'h19, ack);
        d = 8'hff;
        if (ack)
            m.read_byte(d, 1'h1);
        m.stop();
    endtask : ara

    initial
    begin
        {resetn, addr_select_0, interrupt_mode_wr, interrupt_mode_wdata} = 4'h0;
        {alert_polarity, temp_alert_set, temp_alert_below_low} = 3'h0;
        addr_select_1 = 1'h1;
        tx_data = 8'hc3;
        repeat (10) @(posedge clock);
        resetn <= 1'h1;
        repeat (4) @(negedge clock);
        check("slave_addr", slave_addr, 7'h4c);
        check("hs_mode", hs_mode, 8'h0);
        xfer(8'h98, 8'ha5);
        check("write ack", {ack, ack2}, 8'h3);
        check("rx_data", rx_data, 8'ha5);
        check("bus_free", bus_free, 8'h1);
        $display("test own write done");
        pulse(1'h0, 1'h0, 1'h1);
        check("alert off mode", alert_pending, 8'h0);
        pulse(1'h1, 1'h1, 1'h0);
        check("mode bit", interrupt_mode_select, 8'h1);
        ara();
        check("ara no alert", ack, 8'h0);
        $display("test refusals done");
        for (int i = 0; i < 4; i++)
        begin
            p = i[1];
            b = i[0];
            @(posedge clock);
            alert_polarity <= p;
            temp_alert_below_low <= b;
            pulse(1'h0, 1'h0, 1'h1);
            check("alert_active", alert_active, 8'h1);
            ara();
            check("ara ack", ack, 8'h1);
            check("ara byte", d, {7'h4c, b ^ p});
            check("winner alert", alert_active, 8'h0);
            check("loser alert", alert_pending2, 8'h1);
        end
        ara();
        check("pinless byte", d, {7'h4e, b ^ p});
        check("pinless alert", alert_pending2, 8'h0);
        $display("test alert response done");
        pulse(1'h0, 1'h0, 1'h1);
        @(negedge clock);
        m.start();
        m.write_byte(8'h99, ack);
        m.read_byte(d, 1'h0);
        check("read byte 0", d, 8'hc3);
        m.read_byte(d, 1'h1);
        m.stop();
        check("read byte 1", d, 8'hc3);
        check("read clears", alert_active, 8'h0);
        check("other keeps", alert_pending2, 8'h1);
        $display("test own read done");
        @(posedge clock);
        addr_select_0 <= 1'h1;
        addr_select_1 <= 1'h0;
        xfer(8'h01, 8'h04);
        check("gc read refused", ack, 8'h0);
        xfer(8'h00, 8'h04);
        check("gc latch ack", {ack, ack2}, 8'h3);
        check("relatched addr", slave_addr, 7'h4a);
        check("mode kept", interrupt_mode_select, 8'h1);
        pulse(1'h0, 1'h0, 1'h1);
        xfer(8'h00, 8'h06);
        check("gc reset ack", {ack, ack2}, 8'h3);
        check("mode cleared", interrupt_mode_select, 8'h0);
        check("alert cleared", {alert_active, alert_pending2}, 8'h0);
        $display("test general call done");
        @(negedge clock);
        m.start();
        m.write_byte(8'h0d, ack);
        check("hs code ack", ack, 8'h0);
        check("hs entered", hs_mode, 8'h1);
        m.start();
        m.write_byte(8'h94, ack);
        m.write_byte(8'h5a, ack2);
        check("hs write ack", {ack, ack2}, 8'h3);
        check("hs rx_data", rx_data, 8'h5a);
        m.stop();
        check("hs left", hs_mode, 8'h0);
        $display("test high speed done");
        end_sim();
    end
endmodule : test_sensor_i2c_alert_response
